//--- verilog/rtcc_pkg.sv
// Operation
// - expiry flag set after 2^15 clocks unreturned
// - expiry flags held until one written
// - bit 7 enables host counter, resets 1
// - bit 6 enables card counter, resets 1
// - bit 5 flags card target B expiry
// - bit 3 flags card target A expiry
// - bit 1 flags host target expiry
// - retry bits 4,2,0 read zero
// - ring enable gates ring output routing
// - ring enable shared by both functions
// - video mode tri-states socket video pins
// - port select picks video priority socket
// - audio route bit, socket 0 wins
// - speaker out is XOR of enabled inputs
// - speaker pin driven only when enabled
// - card interrupt sets per-socket flag bit 0
// - interrupt flag cleared by writing one
// - card control bits 4,3 read zero
package rtcc_pkg;
  // configuration offsets
  localparam logic [7:0] RETRY_OFS = 8'h90;
  localparam logic [7:0] CARD_OFS = 8'h91;
  // reset values
  localparam logic [7:0] RETRY_RST = 8'hc0;
  localparam logic [7:0] CARD_RST = 8'h00;
  // retry register fields
  localparam int HOST_EN_BIT = 7;
  localparam int CARD_EN_BIT = 6;
  localparam int TGT_B_BIT = 5;
  localparam int TGT_A_BIT = 3;
  localparam int HOST_EXP_BIT = 1;
  // card control fields
  localparam int RING_EN_BIT = 7;
  localparam int VIDEO_BIT = 6;
  localparam int PORT_SEL_BIT = 5;
  localparam int AUDIO_BIT = 2;
  localparam int SPK_BIT = 1;
  localparam int IRQ_BIT = 0;
  // retry timeout: 2^15 clock cycles
  localparam int RETRY_LOG2 = 15;
  localparam int RETRY_CYCLES = 2 ** RETRY_LOG2;

  // one configuration access, taken in one cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic func;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtcc_cfg_t;

  // retry handshake events from one bridge side
  typedef struct packed {
    logic issued;
    logic returned;
  } rtcc_retry_t;
endpackage : rtcc_pkg

//--- verilog/rtcc_retry_timer.sv
`timescale 1ns/100ps
module rtcc_retry_timer #(
  parameter int LIMIT = rtcc_pkg::RETRY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic enable,
  input wire rtcc_pkg::rtcc_retry_t ev,
  output logic expired
);
  localparam int CW = $clog2(LIMIT) + 1;
  localparam logic [CW-1:0] LAST = CW'(LIMIT - 1);

  logic active_r; // a retried master is outstanding
  logic [CW-1:0] cnt_r; // cycles since the retry

  // counting; a new retry while active restarts the window
  always_ff @(posedge ref_clk) begin
    if (!rstn || !enable) begin
      active_r <= 1'b0;
      cnt_r <= '0;
    end else if (ev.returned) begin
      active_r <= 1'b0;
      cnt_r <= '0;
    end else if (ev.issued) begin
      active_r <= 1'b1;
      cnt_r <= '0;
    end else if (active_r) begin
      if (cnt_r == LAST) begin
        active_r <= 1'b0; // one expiry per retry
      end
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  // expiry pulse, registered
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      expired <= 1'b0;
    end else begin
      expired <= enable && active_r && !ev.returned && !ev.issued && (cnt_r == LAST);
    end
  end

  a_no_exp_disabled: assert property (@(posedge ref_clk) disable iff (!rstn)
    !enable |=> !active_r) else $error("timer active while disabled");
  a_ret_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
    ev.returned |=> !active_r && cnt_r == '0) else $error("return did not clear");
endmodule : rtcc_retry_timer

//--- verilog/rtcc_top.sv
`timescale 1ns/100ps
module rtcc_top #(
  parameter int RETRY_LIMIT = rtcc_pkg::RETRY_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire rtcc_pkg::rtcc_cfg_t cfg,
  output logic [7:0] cfg_rdata,
  output logic cfg_rvalid,
  input wire rtcc_pkg::rtcc_retry_t host_retry,
  input wire rtcc_pkg::rtcc_retry_t card_a_retry,
  input wire rtcc_pkg::rtcc_retry_t card_b_retry,
  input wire logic ring_indicate_output,
  input wire logic ring_mux_select,
  input wire logic [1:0] card_func_irq,
  input wire logic [1:0] card_audio_in,
  input wire logic [1:0] card_speaker_in,
  output logic ring_pme_out,
  output logic multi_pin_2,
  output logic multi_pin_4,
  output logic [1:0] video_pins_hiz,
  output logic video_select_sock0,
  output logic video_select_sock1,
  output logic audio_pin_output,
  output logic speaker_pin_out,
  output logic speaker_pin_oe
);
  // status and control state
  logic host_retry_count_en_r; // host side counter enable
  logic card_retry_count_en_r; // card side counter enable
  logic card_target_b_expired_r;
  logic card_target_a_expired_r;
  logic host_target_expired_r;
  logic ring_out_enable_r; // one bit for both functions
  logic [1:0] video_port_mode_r; // per function
  logic [1:0] port_sel_r; // per function
  logic [1:0] audio_to_pin_route_r; // per function
  logic [1:0] speaker_route_en_r; // per function
  logic [1:0] card_func_irq_flag_r; // per function

  // pin synchronisers; stage one feeds stage two only
  logic [1:0] aud_s1_r;
  logic [1:0] aud_s2_r;
  logic [1:0] spk_s1_r;
  logic [1:0] spk_s2_r;

  // timer expiry pulses
  logic host_exp;
  logic card_a_exp;
  logic card_b_exp;

  // write decode, both functions decode both offsets
  logic wr_retry;
  logic wr_card;
  logic [7:0] wd;
  assign wr_retry = cfg.wr && (cfg.addr == rtcc_pkg::RETRY_OFS);
  assign wr_card = cfg.wr && (cfg.addr == rtcc_pkg::CARD_OFS);
  assign wd = cfg.wdata;

  // one timer per retried target
  // both card targets share one enable, as software sees a single bit
  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_host_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(host_retry_count_en_r),
    .ev(host_retry),
    .expired(host_exp)
  );
  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_a_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(card_retry_count_en_r),
    .ev(card_a_retry),
    .expired(card_a_exp)
  );
  rtcc_retry_timer #(.LIMIT(RETRY_LIMIT)) u_card_b_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .enable(card_retry_count_en_r),
    .ev(card_b_retry),
    .expired(card_b_exp)
  );

  // write-one-to-clear with set priority
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    w1c = set | (cur & ~clr);
  endfunction : w1c

  // counter enables, shared retry register storage
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      host_retry_count_en_r <= rtcc_pkg::RETRY_RST[rtcc_pkg::HOST_EN_BIT];
      card_retry_count_en_r <= rtcc_pkg::RETRY_RST[rtcc_pkg::CARD_EN_BIT];
    end else if (wr_retry) begin
      host_retry_count_en_r <= wd[rtcc_pkg::HOST_EN_BIT];
      card_retry_count_en_r <= wd[rtcc_pkg::CARD_EN_BIT];
    end
  end

  // expiry flags; an expiry in the clearing cycle still lands
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      card_target_b_expired_r <= 1'b0;
      card_target_a_expired_r <= 1'b0;
      host_target_expired_r <= 1'b0;
    end else begin
      card_target_b_expired_r <= w1c(card_target_b_expired_r, card_b_exp,
                                     wr_retry & wd[rtcc_pkg::TGT_B_BIT]);
      card_target_a_expired_r <= w1c(card_target_a_expired_r, card_a_exp,
                                     wr_retry & wd[rtcc_pkg::TGT_A_BIT]);
      host_target_expired_r <= w1c(host_target_expired_r, host_exp,
                                   wr_retry & wd[rtcc_pkg::HOST_EXP_BIT]);
    end
  end

  // shared ring enable, written through either function
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ring_out_enable_r <= rtcc_pkg::CARD_RST[rtcc_pkg::RING_EN_BIT];
    end else if (wr_card) begin
      ring_out_enable_r <= wd[rtcc_pkg::RING_EN_BIT];
    end
  end

  // per-function card control bits
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      video_port_mode_r <= {2{rtcc_pkg::CARD_RST[rtcc_pkg::VIDEO_BIT]}};
      port_sel_r <= {2{rtcc_pkg::CARD_RST[rtcc_pkg::PORT_SEL_BIT]}};
      audio_to_pin_route_r <= {2{rtcc_pkg::CARD_RST[rtcc_pkg::AUDIO_BIT]}};
      speaker_route_en_r <= {2{rtcc_pkg::CARD_RST[rtcc_pkg::SPK_BIT]}};
    end else if (wr_card) begin
      video_port_mode_r[cfg.func] <= wd[rtcc_pkg::VIDEO_BIT];
      port_sel_r[cfg.func] <= wd[rtcc_pkg::PORT_SEL_BIT];
      audio_to_pin_route_r[cfg.func] <= wd[rtcc_pkg::AUDIO_BIT];
      speaker_route_en_r[cfg.func] <= wd[rtcc_pkg::SPK_BIT];
    end
  end

  // functional interrupt flags, socket dependent
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      card_func_irq_flag_r <= {2{rtcc_pkg::CARD_RST[rtcc_pkg::IRQ_BIT]}};
    end else begin
      for (int s = 0; s < 2; s++) begin
        card_func_irq_flag_r[s] <= w1c(card_func_irq_flag_r[s], card_func_irq[s],
          wr_card && (cfg.func == 1'(s)) && wd[rtcc_pkg::IRQ_BIT]);
      end
    end
  end

  // read data; reserved positions tie to zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a, input logic f);
    logic [7:0] v;
    v = 8'h00;
    if (a == rtcc_pkg::RETRY_OFS) begin
      v[rtcc_pkg::HOST_EN_BIT] = host_retry_count_en_r;
      v[rtcc_pkg::CARD_EN_BIT] = card_retry_count_en_r;
      v[rtcc_pkg::TGT_B_BIT] = card_target_b_expired_r;
      v[rtcc_pkg::TGT_A_BIT] = card_target_a_expired_r;
      v[rtcc_pkg::HOST_EXP_BIT] = host_target_expired_r;
    end else if (a == rtcc_pkg::CARD_OFS) begin
      // per-function fields come from the function the access names
      v[rtcc_pkg::RING_EN_BIT] = ring_out_enable_r;
      v[rtcc_pkg::VIDEO_BIT] = video_port_mode_r[f];
      v[rtcc_pkg::PORT_SEL_BIT] = port_sel_r[f];
      v[rtcc_pkg::AUDIO_BIT] = audio_to_pin_route_r[f];
      v[rtcc_pkg::SPK_BIT] = speaker_route_en_r[f];
      v[rtcc_pkg::IRQ_BIT] = card_func_irq_flag_r[f];
    end
    rd_mux = v;
  endfunction : rd_mux

  // read answer one cycle after the request; unmapped reads give zero
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg.rd;
      cfg_rdata <= cfg.rd ? rd_mux(cfg.addr, cfg.func) : 8'h00;
    end
  end

  // synchronise card pin inputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      aud_s1_r <= 2'h0;
      aud_s2_r <= 2'h0;
      spk_s1_r <= 2'h0;
      spk_s2_r <= 2'h0;
    end else begin
      aud_s1_r <= card_audio_in;
      aud_s2_r <= aud_s1_r;
      spk_s1_r <= card_speaker_in;
      spk_s2_r <= spk_s1_r;
    end
  end

  // ring routing; the pin mux beyond picks which pin really carries it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      ring_pme_out <= 1'b0;
      multi_pin_2 <= 1'b0;
      multi_pin_4 <= 1'b0;
    end else begin
      ring_pme_out <= ring_out_enable_r && !ring_mux_select && ring_indicate_output;
      multi_pin_2 <= ring_out_enable_r && ring_indicate_output;
      multi_pin_4 <= ring_out_enable_r && ring_indicate_output;
    end
  end

  // video port tri-state and select priority
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      video_pins_hiz <= 2'h0;
      video_select_sock0 <= 1'b0;
      video_select_sock1 <= 1'b0;
    end else begin
      video_pins_hiz <= video_port_mode_r;
      if (&video_port_mode_r) begin
        // both in video mode: the port select of socket 0's function decides
        video_select_sock0 <= !port_sel_r[0];
        video_select_sock1 <= port_sel_r[0];
      end else begin
        // at most one socket in video mode: that socket keeps the port
        video_select_sock0 <= video_port_mode_r[0];
        video_select_sock1 <= video_port_mode_r[1];
      end
    end
  end

  // audio to multifunction pin, socket 0 first
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      audio_pin_output <= 1'b0;
    end else if (audio_to_pin_route_r[0]) begin
      audio_pin_output <= aud_s2_r[0];
    end else if (audio_to_pin_route_r[1]) begin
      audio_pin_output <= aud_s2_r[1];
    end else begin
      // no route bit set: hold the pin low rather than leave stale audio
      audio_pin_output <= 1'b0;
    end
  end

  // speaker merge; pin left undriven when neither enable is set
  // data is forced low while undriven, so the pin mux never sees stale levels
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      speaker_pin_out <= 1'b0;
      speaker_pin_oe <= 1'b0;
    end else begin
      speaker_pin_out <= |(spk_s2_r & speaker_route_en_r) ? ^(spk_s2_r & speaker_route_en_r) : 1'b0;
      speaker_pin_oe <= |speaker_route_en_r;
    end
  end

  // flag, read data and pin routing checks, one rule each
  a_host_exp_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    host_exp |=> host_target_expired_r) else $error("host expiry not flagged");
  a_flag_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    host_target_expired_r && !(wr_retry && wd[rtcc_pkg::HOST_EXP_BIT]) |=> host_target_expired_r)
    else $error("host expiry flag lost");
  a_host_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_retry && wd[rtcc_pkg::HOST_EXP_BIT] && !host_exp |=> !host_target_expired_r)
    else $error("host flag not cleared");
  a_b_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    card_b_exp |=> card_target_b_expired_r) else $error("target b expiry not flagged");
  a_b_clear: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_retry && wd[rtcc_pkg::TGT_B_BIT] && !card_b_exp |=> !card_target_b_expired_r)
    else $error("target b flag not cleared");
  a_a_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    card_a_exp |=> card_target_a_expired_r) else $error("target a expiry not flagged");
  a_retry_rsvd: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg.rd && cfg.addr == rtcc_pkg::RETRY_OFS |=> (cfg_rdata & 8'h15) == 8'h00)
    else $error("retry reserved bits nonzero");
  a_card_rsvd: assert property (@(posedge ref_clk) disable iff (!rstn)
    cfg.rd && cfg.addr == rtcc_pkg::CARD_OFS |=> (cfg_rdata & 8'h18) == 8'h00)
    else $error("card reserved bits nonzero");
  a_ring_block: assert property (@(posedge ref_clk) disable iff (!rstn)
    !ring_out_enable_r |=> !ring_pme_out && !multi_pin_2 && !multi_pin_4)
    else $error("ring routed while disabled");
  a_ring_shared: assert property (@(posedge ref_clk) disable iff (!rstn)
    wr_card |=> ring_out_enable_r == $past(wd[rtcc_pkg::RING_EN_BIT]))
    else $error("ring enable not shared");
  a_spk_oe: assert property (@(posedge ref_clk) disable iff (!rstn)
    speaker_route_en_r == 2'h0 ##1 speaker_route_en_r == 2'h0 |-> !speaker_pin_oe)
    else $error("speaker driven while disabled");
  a_spk_single: assert property (@(posedge ref_clk) disable iff (!rstn)
    speaker_route_en_r == 2'h1 |=> speaker_pin_out == $past(spk_s2_r[0]))
    else $error("speaker data wrong");
  a_irq_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    card_func_irq[1] |=> card_func_irq_flag_r[1]) else $error("irq flag not set");
  a_irq0_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    card_func_irq[0] |=> card_func_irq_flag_r[0]) else $error("socket 0 irq flag not set");
  a_irq_holds: assert property (@(posedge ref_clk) disable iff (!rstn)
    card_func_irq_flag_r[0] && !(wr_card && !cfg.func && wd[rtcc_pkg::IRQ_BIT]) |=> card_func_irq_flag_r[0])
    else $error("irq flag lost");
  a_video_prio: assert property (@(posedge ref_clk) disable iff (!rstn)
    &video_port_mode_r |=> video_select_sock1 == $past(port_sel_r[0]) && video_select_sock0 != video_select_sock1)
    else $error("video priority wrong");
  a_hiz_follows: assert property (@(posedge ref_clk) disable iff (!rstn)
    1'b1 |=> video_pins_hiz == $past(video_port_mode_r)) else $error("video tri-state wrong");
  a_audio_prio: assert property (@(posedge ref_clk) disable iff (!rstn)
    audio_to_pin_route_r[0] |=> audio_pin_output == $past(aud_s2_r[0]))
    else $error("audio routing wrong");
endmodule : rtcc_top

//--- test/rtcc_master_model.sv
`timescale 1ns/100ps
// retried bus master: either comes back after a set delay or never
module rtcc_master_model (
  input wire logic ref_clk,
  output rtcc_pkg::rtcc_retry_t ev
);
  // quiet until a retry is asked for
  initial begin
    ev = '0;
  end
  // back = 0 means the master never returns; pulses change off the sampling edge
  task automatic retry(input int back);
    @(negedge ref_clk);
    ev.issued = 1'b1;
    @(negedge ref_clk);
    ev.issued = 1'b0;
    if (back > 0) begin
      repeat (back - 1) @(negedge ref_clk);
      ev.returned = 1'b1;
      @(negedge ref_clk);
      ev.returned = 1'b0;
    end
  endtask : retry
endmodule : rtcc_master_model

//--- test/tb.sv
`timescale 1ns/100ps
module tb;
  localparam int LIM = 16; // short retry limit keeps the run brief
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  rtcc_pkg::rtcc_cfg_t cfg;
  logic [7:0] cfg_rdata;
  logic cfg_rvalid;
  rtcc_pkg::rtcc_retry_t host_ev, a_ev, b_ev;
  logic ring;
  logic rmux;
  logic [1:0] irq, aud, spk;
  logic ring_pme, mp2, mp4, v_s0, v_s1, aud_o, spk_o, spk_oe;
  logic [1:0] hiz;
  int n_errors = 0, n_tests = 0, cyc = 0;
  // reference model: one shared retry register, card register per function
  logic [7:0] m_retry = 8'hc0;
  logic m_ring = 1'b0;
  logic [7:0] m_card [2] = '{8'h00, 8'h00};
  logic [7:0] rd;

  always #4 ref_clk = ~ref_clk;

  rtcc_top #(.RETRY_LIMIT(LIM)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .cfg(cfg), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
    .host_retry(host_ev), .card_a_retry(a_ev), .card_b_retry(b_ev),
    .ring_indicate_output(ring), .ring_mux_select(rmux), .card_func_irq(irq),
    .card_audio_in(aud), .card_speaker_in(spk), .ring_pme_out(ring_pme),
    .multi_pin_2(mp2), .multi_pin_4(mp4), .video_pins_hiz(hiz),
    .video_select_sock0(v_s0), .video_select_sock1(v_s1), .audio_pin_output(aud_o),
    .speaker_pin_out(spk_o), .speaker_pin_oe(spk_oe)
  );
  rtcc_master_model u_host (.ref_clk(ref_clk), .ev(host_ev));
  rtcc_master_model u_ca (.ref_clk(ref_clk), .ev(a_ev));
  rtcc_master_model u_cb (.ref_clk(ref_clk), .ev(b_ev));

  // one comparison, counted
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // write one byte and mirror it in the model
  task automatic wr(input logic f, input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    cfg = '{1'b1, 1'b0, f, a, d};
    @(negedge ref_clk);
    cfg.wr = 1'b0;
    if (a == rtcc_pkg::RETRY_OFS) begin
      m_retry = {d[7:6], m_retry[5:0] & ~d[5:0] & 6'h2a};
    end
    if (a == rtcc_pkg::CARD_OFS) begin
      m_ring = d[7];
      m_card[f] = {1'b0, d[6:5], 2'b00, d[2:1], m_card[f][0] & ~d[0]};
    end
  endtask : wr

  // read one byte; the answer stands only in the cycle after the request
  task automatic cmp(input logic f, input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == rtcc_pkg::RETRY_OFS) e = m_retry;
    if (a == rtcc_pkg::CARD_OFS) e = {m_ring, m_card[f][6:0]};
    @(negedge ref_clk);
    cfg = '{1'b0, 1'b1, f, a, 8'h00};
    @(negedge ref_clk);
    cfg.rd = 1'b0;
    // answer launched at the edge just passed, gone after the next one
    chk("rvalid", 8'h01, {7'h00, cfg_rvalid});
    chk("register", e, cfg_rdata);
  endtask : cmp

  // pin outputs after register, pipeline and synchroniser delays
  task automatic chk_pins();
    logic [1:0] vm, sp;
    logic ps;
    repeat (4) @(negedge ref_clk);
    vm = {m_card[1][6], m_card[0][6]};
    sp = {m_card[1][1], m_card[0][1]};
    ps = m_card[0][5];
    chk("ring", {5'h0, m_ring & ~rmux & ring, m_ring & ring, m_ring & ring}, {5'h0, ring_pme, mp2, mp4});
    chk("video", {4'h0, vm, vm == 2'b10 || (vm == 2'b11 && ps), vm == 2'b01 || (vm == 2'b11 && !ps)},
        {4'h0, hiz, v_s1, v_s0});
    chk("audio", {7'h0, m_card[0][2] ? aud[0] : (m_card[1][2] & aud[1])}, {7'h0, aud_o});
    chk("speaker", {6'h0, |sp, ^(spk & sp)}, {6'h0, spk_oe, spk_o});
  endtask : chk_pins

  // single exit point of the run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // hang guard, far above the several hundred cycles the tests need
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    logic f;
    void'($urandom(32'hf5204e44));
    cfg = '0;
    ring = 1'b0;
    rmux = 1'b0;
    irq = 2'h0;
    aud = 2'h0;
    spk = 2'h0;
    repeat (16) @(negedge ref_clk);
    rstn = 1'b1;
    // reset values and an unmapped offset, in both functions
    for (int i = 0; i < 2; i++) begin
      cmp(i[0], rtcc_pkg::RETRY_OFS);
      cmp(i[0], rtcc_pkg::CARD_OFS);
      cmp(i[0], 8'h92);
    end
    // reserved bits stay zero, enables follow writes
    wr(0, rtcc_pkg::RETRY_OFS, 8'hff);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'h00);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'hc0);
    $display("test reset done");
    // masters that never come back on every target
    u_host.retry(0);
    u_ca.retry(0);
    u_cb.retry(0);
    repeat (LIM + 4) @(negedge ref_clk);
    m_retry = 8'hea;
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'hc0);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'hc2);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'he8);
    cmp(0, rtcc_pkg::RETRY_OFS);
    $display("test expiry done");
    // a master back just in time, then retries with counters off
    u_host.retry(LIM - 2);
    repeat (LIM + 4) @(negedge ref_clk);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'h40);
    u_host.retry(0);
    wr(0, rtcc_pkg::RETRY_OFS, 8'h80);
    u_ca.retry(0);
    u_cb.retry(0);
    repeat (LIM + 4) @(negedge ref_clk);
    cmp(0, rtcc_pkg::RETRY_OFS);
    wr(0, rtcc_pkg::RETRY_OFS, 8'hc0);
    $display("test idle counters done");
    // functional interrupt flags, one socket at a time
    for (int s = 0; s < 2; s++) begin
      @(negedge ref_clk);
      irq = 2'b01 << s;
      @(negedge ref_clk);
      irq = 2'b00;
      m_card[s][0] = 1'b1;
      cmp(0, rtcc_pkg::CARD_OFS);
      cmp(1, rtcc_pkg::CARD_OFS);
      wr(s[0], rtcc_pkg::CARD_OFS, 8'h00);
      cmp(s[0], rtcc_pkg::CARD_OFS);
      wr(s[0], rtcc_pkg::CARD_OFS, 8'h01);
      cmp(s[0], rtcc_pkg::CARD_OFS);
    end
    $display("test interrupt flag done");
    // random control bytes and pin levels
    repeat (60) begin
      f = 1'($urandom);
      wr(f, rtcc_pkg::CARD_OFS, 8'($urandom));
      ring = 1'($urandom);
      rmux = 1'($urandom);
      aud = 2'($urandom);
      spk = 2'($urandom);
      chk_pins();
      cmp(~f, rtcc_pkg::CARD_OFS);
    end
    $display("test pins done");
    report_and_stop();
  end
endmodule : tb
